// ---- verilog/ssu_serial_unit.sv ----
// module: universal serial shift unit with edge counter and start detector
//
// Function
// - start detector flags bus starts only in two-wire modes
// - data line is delayed before the clock level is judged
// - start detector can wake the processor without its clock
// - two-wire slave holds clock low until ready for more data
// - external clock counts on both rising and falling pin edges
// - counter chains with the timer compare match into a wider counter
// - counter preset to maximum overflows on the next external edge
// - data register is the shift register; a write beats a shift
// - shift toward msb on external edge, timer match or software strobe
// - inputs feed shifter and counter even with outputs disabled
// - serial data output comes from shift msb through a latch
// - latch open first half clock when external, always when internal
// - start flag on start condition, or on external clock edges in other modes
// - start flag interrupts and wakes; write one clears and releases hold
// - overflow flag on wrap; cleared by write one or buffer read
// - stop flag on stop condition in two-wire, cleared by write one
// - collision bit shows shift msb differing from data pin level
// - counter readable, writable, advancing once per selected clock
// - external source with software bit makes toggle strobe clock counter
// - pending flag interrupts as soon as its enables are set
// - second two-wire mode also holds clock low after overflow
// - with internal strobe source the software bit clocks once
//
// Chosen here: the APB slave port.
module ssu_serial_unit (
  input wire logic sys_clk, // system clock, 10 mhz
  input wire logic sys_rst, // synchronous reset, active high
  input wire ssu_pkg::ssu_apb_req_t apb_req, // apb request from master
  output ssu_pkg::ssu_apb_rsp_t apb_rsp, // apb answer
  input wire logic timer_cmp_match, // timer compare match pulse
  input wire logic global_irq_enable, // global interrupt enable level
  input wire logic serial_in_pin_in, // data pin level (di or sda)
  input wire logic serial_clock_pin_in, // clock pin level (serial_clock_pin or scl)
  output ssu_pkg::ssu_pins_t pins, // pin drivers and enables
  output logic start_irq, // start condition interrupt request
  output logic overflow_irq, // counter overflow interrupt request
  output logic start_wake // wake request from start flag
);

  localparam int unsigned DW = ssu_pkg::SDA_DELAY_CYC;

  ssu_pkg::ssu_state_t q;
  ssu_pkg::ssu_state_t d;

  // bus decode
  logic [ssu_pkg::IDX_W-1:0] idx;
  logic hit_ctl;
  logic hit_sts;
  logic hit_data;
  logic hit_buf;
  logic hit_pin;
  logic mapped;
  logic setup;
  logic wr;
  logic rd;

  // clock and event terms
  logic clk_rise;
  logic clk_fall;
  logic clk_edge;
  logic wr_ctl;
  logic [1:0] wcs;
  logic sw_strobe;
  logic tc_strobe;
  logic tc_count;
  logic timer_clk;
  logic shift_ext;
  logic shift_clk;
  logic cnt_clk;
  logic ovf_evt;
  logic start_det;
  logic stop_det;
  logic start_evt;
  logic two_wire;
  logic three_wire;
  logic latch_open;
  logic clk_hold;
  logic collision;
  logic [7:0] status_rd;

  // address decode on the word index
  always_comb begin
    idx = apb_req.paddr[ssu_pkg::APB_AW-1:2];
    hit_ctl = (idx == ssu_pkg::IDX_CONTROL);
    hit_sts = (idx == ssu_pkg::IDX_STATUS);
    hit_data = (idx == ssu_pkg::IDX_DATA);
    hit_buf = (idx == ssu_pkg::IDX_BUFFER);
    hit_pin = (idx == ssu_pkg::IDX_PINCTL);
    mapped = hit_ctl | hit_sts | hit_data | hit_buf | hit_pin;
    setup = apb_req.psel & ~apb_req.penable;
    // side effects only in the access phase, and only to mapped words
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped;
    rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite & mapped;
  end

  // edges of the synchronised clock pin
  always_comb begin
    clk_rise = q.clk_s2 & ~q.clk_prev;
    clk_fall = ~q.clk_s2 & q.clk_prev;
    // edges closer than two samples merge; the far side keeps to fck/4
    clk_edge = clk_rise | clk_fall;
  end

  // bus conditions, judged against the delayed data line
  always_comb begin
    two_wire = q.wm[1];
    three_wire = (q.wm == ssu_pkg::WM_THREE);
    // sda is compared a cycle late so scl has settled when sda moves
    start_det = q.clk_s2 & q.sda_dly[DW] & ~q.sda_dly[DW-1];
    stop_det = q.clk_s2 & ~q.sda_dly[DW] & q.sda_dly[DW-1];
    // start detection gated to two-wire, edge mode only otherwise
    start_evt = (two_wire & start_det)
              | (~two_wire & q.cs[1] & ~q.clk_sel & clk_edge);
  end

  // clock sources for shifter and counter
  always_comb begin
    wr_ctl = wr & hit_ctl;
    wcs = apb_req.pwdata[ssu_pkg::CTL_CS_LO +: 2];
    // one shot from the software bit when the strobe source is chosen
    sw_strobe = wr_ctl & (wcs == ssu_pkg::CS_SW)
              & apb_req.pwdata[ssu_pkg::CTL_CLK];
    tc_strobe = wr_ctl & apb_req.pwdata[ssu_pkg::CTL_TC];
    // toggle strobe clocks the counter when an external source and software clocking are picked
    tc_count = tc_strobe & wcs[1] & apb_req.pwdata[ssu_pkg::CTL_CLK];
    // timer match source lets the counter extend the timer
    timer_clk = (q.cs == ssu_pkg::CS_TIMER) & timer_cmp_match;
    // cs0 picks the sampling edge of the external clock
    shift_ext = q.cs[1] & (q.cs[0] ? clk_fall : clk_rise);
    shift_clk = sw_strobe | timer_clk | shift_ext;
    // external counting sees both edges of the clock pin
    cnt_clk = sw_strobe | timer_clk | tc_count
            | (q.cs[1] & ~q.clk_sel & clk_edge);
    // a counter write wins, so no wrap happens in that cycle
    ovf_evt = cnt_clk & (q.cnt == ssu_pkg::CNT_MAX)
            & ~(wr & hit_sts);
  end

  // output latch and line hold
  always_comb begin
    // external clock: open only in the half before the sampling edge
    latch_open = ~q.cs[1] | (q.clk_s2 == q.cs[0]);
    clk_hold = q.start_hold
             | ((q.wm == ssu_pkg::WM_TWO_HOLD) & q.ovf);
    collision = q.data[7] ^ q.sda_s2;
    status_rd = {q.start, q.ovf, q.stop, collision, q.cnt};
  end

  // next state of every register
  always_comb begin
    d = q;

    // two-stage synchronisers, then a delay line for the data pin
    d.clk_s1 = serial_clock_pin_in;
    d.clk_s2 = q.clk_s1;
    d.clk_prev = q.clk_s2;
    d.sda_s1 = serial_in_pin_in;
    d.sda_s2 = q.sda_s1;
    d.sda_dly = {q.sda_dly[DW-1:0], q.sda_s2};

    // read data is caught in setup so it stands through the access phase
    if (setup) begin
      d.slverr = ~mapped;
      d.prdata = 32'h0000_0000;
      if (hit_ctl) begin
        d.prdata[7:0] = {q.sie, q.oie, q.wm, q.cs, 2'h0};
      end
      if (hit_sts) begin
        d.prdata[7:0] = status_rd;
      end
      if (hit_data) begin
        d.prdata[7:0] = q.data;
      end
      if (hit_buf) begin
        d.prdata[7:0] = q.buffer;
      end
      if (hit_pin) begin
        d.prdata[3:0] = q.pinctl;
      end
    end

    // control register; the toggle strobe bit is never stored, the clock bit is kept in clk_sel
    if (wr_ctl) begin
      d.sie = apb_req.pwdata[ssu_pkg::CTL_SIE];
      d.oie = apb_req.pwdata[ssu_pkg::CTL_OIE];
      d.wm = apb_req.pwdata[ssu_pkg::CTL_WM_LO +: 2];
      d.cs = wcs;
      d.clk_sel = apb_req.pwdata[ssu_pkg::CTL_CLK];
    end

    // pin control, then the toggle strobe flips the clock port level
    if (wr & hit_pin) begin
      d.pinctl = apb_req.pwdata[3:0];
    end
    if (tc_strobe) begin
      d.pinctl[ssu_pkg::PIN_CLOCK_PORT] = ~d.pinctl[ssu_pkg::PIN_CLOCK_PORT];
    end

    // shift register: a cpu write drops a coincident shift
    if (wr & hit_data) begin
      d.data = apb_req.pwdata[7:0];
    end else if (shift_clk) begin
      d.data = {q.data[6:0], q.sda_s2};
    end

    // edge counter, written directly or advanced by the chosen clock
    if (wr & hit_sts) begin
      d.cnt = apb_req.pwdata[3:0];
    end else if (cnt_clk) begin
      d.cnt = 4'(q.cnt + 4'h1);
    end

    // buffer keeps the completed word at the wrap
    if (ovf_evt) begin
      d.buffer = d.data;
    end

    // flags: clear first so a same-cycle event still sets
    if (wr & hit_sts & apb_req.pwdata[ssu_pkg::STS_START]) begin
      d.start = 1'b0;
    end
    if (start_evt) begin
      d.start = 1'b1;
    end
    if ((wr & hit_sts & apb_req.pwdata[ssu_pkg::STS_OVF]) | (rd & hit_buf)) begin
      d.ovf = 1'b0;
    end
    if (ovf_evt) begin
      d.ovf = 1'b1;
    end
    if (wr & hit_sts & apb_req.pwdata[ssu_pkg::STS_STOP]) begin
      d.stop = 1'b0;
    end
    if (two_wire & stop_det) begin
      d.stop = 1'b1;
    end

    // start hold begins once the master pulls scl low after the start
    if (~d.start) begin
      d.start_hold = 1'b0;
    end else if (two_wire & clk_fall) begin
      d.start_hold = 1'b1;
    end

    // output latch follows the shift msb while open
    if (latch_open) begin
      d.latch = d.data[7];
    end

    // pin drivers; two-wire lines are open drain, driven only low
    d.pins.sda_out = 1'b0;
    d.pins.sda_oe = two_wire & q.pinctl[ssu_pkg::PIN_DATA_DIR]
                  & ~(q.latch & q.pinctl[ssu_pkg::PIN_DATA_PORT]);
    d.pins.do_out = q.latch;
    d.pins.do_oe = three_wire & q.pinctl[ssu_pkg::PIN_DATA_DIR];
    d.pins.scl_out = three_wire & q.pinctl[ssu_pkg::PIN_CLOCK_PORT];
    d.pins.scl_oe = q.pinctl[ssu_pkg::PIN_CLOCK_DIR]
                  & (three_wire | (two_wire
                  & (~q.pinctl[ssu_pkg::PIN_CLOCK_PORT] | clk_hold)));
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= ssu_pkg::SSU_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // apb answer: zero wait states, error on unmapped words
  always_comb begin
    apb_rsp.prdata = q.prdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & q.slverr;
  end

  // interrupt requests rise at once if the flag was already pending
  always_comb begin
    start_irq = q.start & q.sie & global_irq_enable;
    overflow_irq = q.ovf & q.oie & global_irq_enable;
    // wake is a plain level from the flag, no clock gating inside
    start_wake = q.start;
    pins = q.pins;
  end

endmodule

// ---- verilog/ssu_pkg.sv ----
// package: constants, register map and carrier types of the serial shift unit
package ssu_pkg;

  // apb geometry
  localparam int unsigned APB_AW = 8;
  localparam int unsigned IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h0d;
  localparam logic [5:0] IDX_STATUS = 6'h0e;
  localparam logic [5:0] IDX_DATA = 6'h0f;
  localparam logic [5:0] IDX_BUFFER = 6'h10;
  localparam logic [5:0] IDX_PINCTL = 6'h11;

  // serial_control fields
  localparam int unsigned CTL_SIE = 7;
  localparam int unsigned CTL_OIE = 6;
  localparam int unsigned CTL_WM_LO = 4;
  localparam int unsigned CTL_CS_LO = 2;
  localparam int unsigned CTL_CLK = 1;
  localparam int unsigned CTL_TC = 0;

  // serial_status_counter fields
  localparam int unsigned STS_START = 7;
  localparam int unsigned STS_OVF = 6;
  localparam int unsigned STS_STOP = 5;
  localparam int unsigned STS_COLL = 4;

  // pin control fields
  localparam int unsigned PIN_DATA_DIR = 0;
  localparam int unsigned PIN_CLOCK_DIR = 1;
  localparam int unsigned PIN_DATA_PORT = 2;
  localparam int unsigned PIN_CLOCK_PORT = 3;

  // wire modes and clock sources
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] CS_SW = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [7:0] REG_RST = 8'h00;

  // data line delay ahead of the start detector
  localparam int unsigned SYS_CLK_PERIOD_NS = 100;
  localparam int unsigned SDA_DELAY_NS = 50;
  localparam int unsigned SDA_DELAY_CYC_RAW = (SDA_DELAY_NS + SYS_CLK_PERIOD_NS - 1)
                                              / SYS_CLK_PERIOD_NS;
  localparam int unsigned SDA_DELAY_CYC = (SDA_DELAY_CYC_RAW < 1) ? 1 : SDA_DELAY_CYC_RAW;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } ssu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssu_apb_rsp_t;

  typedef struct packed {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
    logic do_out;
    logic do_oe;
  } ssu_pins_t;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_prev;
    logic sda_s1;
    logic sda_s2;
    logic [SDA_DELAY_CYC:0] sda_dly;
    logic sie;
    logic oie;
    logic [1:0] wm;
    logic [1:0] cs;
    logic clk_sel;
    logic [3:0] pinctl;
    logic [7:0] data;
    logic [7:0] buffer;
    logic [3:0] cnt;
    logic start;
    logic ovf;
    logic stop;
    logic start_hold;
    logic latch;
    ssu_pins_t pins;
    logic [31:0] prdata;
    logic slverr;
  } ssu_state_t;

  localparam ssu_state_t SSU_STATE_RST = '0;

endpackage

// ---- verification/ssu_sva.sv ----
// checker: port-level properties of the serial shift unit
module ssu_sva (
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire ssu_pkg::ssu_apb_req_t apb_req, // apb request
  input wire ssu_pkg::ssu_apb_rsp_t apb_rsp, // apb answer
  input wire logic global_irq_enable, // global enable
  input wire logic serial_in_pin_in, // data pin
  input wire logic serial_clock_pin_in, // clock pin
  input wire logic start_irq, // start request
  input wire logic overflow_irq, // overflow request
  input wire logic start_wake // start flag level
);
  logic [3:0] quiet_q; // cycles since a pin moved, saturating
  logic clr_start;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a write of one to the start bit is the only way to drop the flag
  assign clr_start = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr[7:2] == ssu_pkg::IDX_STATUS && apb_req.pwdata[ssu_pkg::STS_START];
  // pin quiet time; the synchroniser delays edges by a few cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst || $changed(serial_in_pin_in) || $changed(serial_clock_pin_in)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  AST_START_CAUSE: assert property ($rose(start_wake) |-> quiet_q < 4'h8)
    else $error("start flag rose with no pin activity");
  AST_START_HOLD: assert property (start_wake && !clr_start |=> start_wake)
    else $error("start flag dropped without a clear");
  AST_START_GATE: assert property (start_irq |-> start_wake && global_irq_enable)
    else $error("start request without flag and global enable");
  AST_OVF_GATE: assert property (overflow_irq |-> global_irq_enable)
    else $error("overflow request without global enable");
  AST_START_PEND: assert property (start_irq && !apb_req.psel
    |=> start_irq == (start_wake && global_irq_enable))
    else $error("pending start request not following global enable");
  AST_OVF_PEND: assert property (overflow_irq && !apb_req.psel
    |=> overflow_irq == global_irq_enable)
    else $error("pending overflow request not following global enable");
  AST_SLVERR: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("slave error outside access phase");
  AST_PRDATA_HI: assert property (apb_rsp.pready && apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set or not ready");
  COV_START: cover property ($rose(start_wake));
  COV_OVF: cover property ($rose(overflow_irq));
  COV_ERR: cover property (apb_rsp.pslverr);
endmodule

bind ssu_serial_unit ssu_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .global_irq_enable(global_irq_enable),
  .serial_in_pin_in(serial_in_pin_in), .serial_clock_pin_in(serial_clock_pin_in),
  .start_irq(start_irq), .overflow_irq(overflow_irq), .start_wake(start_wake));

// ---- verification/ssu_partner.sv ----
// partner: open-drain serial master on the clock and data lines
module ssu_partner (
  input wire logic sys_clk, // system clock
  input wire ssu_pkg::ssu_pins_t pins, // unit pin drivers
  output logic scl_line, // resolved clock line
  output logic sda_line // resolved data line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // pulled-up lines: low when either party pulls
  assign scl_line = scl_q && !(pins.scl_oe && !pins.scl_out);
  assign sda_line = sda_q && !(pins.sda_oe && !pins.sda_out);
  // each level lasts half of an 800 ns period, well under fck/4
  task automatic drive(input logic c, input logic d);
    scl_q <= c;
    sda_q <= d;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ---- verification/ssu_serial_unit_bench.sv ----
// bench: directed and random checks of the serial shift unit
module ssu_serial_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] I_CTL = ssu_pkg::IDX_CONTROL;
  localparam logic [5:0] I_STS = ssu_pkg::IDX_STATUS;
  localparam logic [5:0] I_DAT = ssu_pkg::IDX_DATA;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_cmp_match = 1'b0;
  logic global_irq_enable = 1'b0;
  logic scl_line, sda_line, start_irq, overflow_irq, start_wake, e;
  ssu_pkg::ssu_apb_req_t apb_req = '0;
  ssu_pkg::ssu_apb_rsp_t apb_rsp;
  ssu_pkg::ssu_pins_t pins;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  logic [31:0] lfsr = 32'h000102aa;
  logic [7:0] q, w, d;
  always #50 sys_clk = ~sys_clk;
  ssu_serial_unit dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .timer_cmp_match(timer_cmp_match),
    .global_irq_enable(global_irq_enable), .serial_in_pin_in(sda_line),
    .serial_clock_pin_in(scl_line), .pins(pins), .start_irq(start_irq),
    .overflow_irq(overflow_irq), .start_wake(start_wake));
  ssu_partner partner (.sys_clk(sys_clk), .pins(pins), .scl_line(scl_line),
    .sda_line(sda_line));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // one apb transfer; an optional timer match lands on the access edge
  task automatic apb(input logic wr, input logic [5:0] i, input logic [7:0] v, input logic tm);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {i, 2'h0}, pwdata: {24'h0, v}};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    timer_cmp_match <= tm;
    @(posedge sys_clk);
    while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
    q = apb_rsp.prdata[7:0];
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    timer_cmp_match <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    apb(1'b1, i, v, 1'b0);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00, 1'b0);
    check(q, x);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, about twenty times the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdc(I_CTL, 8'h00);
    rdc(I_STS, 8'h10);
    apb(1'b0, 6'h3f, 8'h00, 1'b0);
    check({7'h0, e}, 8'h01);
    // software strobe: sixteen clocks wrap the counter
    w = lfsr[7:0];
    lfsr = nxt(lfsr);
    wr(I_DAT, w);
    wr(I_STS, 8'hf0);
    global_irq_enable <= 1'b1;
    for (n = 1; n <= 16; n++) begin
      wr(I_CTL, 8'h42);
      if (n == 4) rdc(I_DAT, {w[3:0], 4'hf});
      if (n == 4) rdc(I_STS, {3'h0, ~w[3], 4'h4});
    end
    rdc(I_STS, 8'h40);
    check({7'h0, overflow_irq}, 8'h01);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({7'h0, overflow_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    @(posedge sys_clk);
    check({7'h0, overflow_irq}, 8'h01);
    rdc(ssu_pkg::IDX_BUFFER, 8'hff);
    rdc(I_STS, 8'h00);
    // timer match: a write on the same edge wins, later matches shift
    wr(I_CTL, 8'h04);
    w = lfsr[15:8];
    apb(1'b1, I_DAT, w, 1'b1);
    rdc(I_DAT, w);
    wr(I_STS, 8'h00);
    n = int'(lfsr[2:0]) + 1;
    lfsr = nxt(lfsr);
    d = (w << n) | ((8'h01 << n) - 8'h01);
    repeat (n) begin
      timer_cmp_match <= 1'b1;
      @(posedge sys_clk);
      timer_cmp_match <= 1'b0;
      @(posedge sys_clk);
    end
    rdc(I_DAT, d);
    rdc(I_STS, {3'h0, ~d[7], 4'(n)});
    // external clock, outputs off: preset counter overflows on one edge
    wr(I_CTL, 8'h08);
    wr(I_DAT, 8'hff);
    wr(I_STS, 8'hef);
    partner.drive(1'b0, 1'b1);
    rdc(I_STS, 8'hc0);
    wr(I_STS, 8'hc0);
    partner.drive(1'b1, 1'b1);
    rdc(I_STS, 8'h81);
    wr(I_STS, 8'h80);
    // software clocking under an external source: toggle strobe counts
    wr(I_CTL, 8'h0b);
    wr(I_CTL, 8'h0b);
    rdc(I_STS, 8'h02);
    wr(I_STS, 8'h00);
    // three-wire: a bus start must not raise the start flag
    wr(I_CTL, 8'h10);
    partner.drive(1'b1, 1'b0);
    partner.drive(1'b1, 1'b1);
    rdc(I_STS, 8'h00);
    // three-wire data out follows a written msb through the open latch
    wr(ssu_pkg::IDX_PINCTL, 8'h01);
    wr(I_DAT, 8'h7f);
    repeat (2) @(posedge sys_clk);
    check({6'h0, pins.do_oe, pins.do_out}, 8'h02);
    wr(I_DAT, 8'hff);
    repeat (2) @(posedge sys_clk);
    check({6'h0, pins.do_oe, pins.do_out}, 8'h03);
    // two-wire slave: start, clock hold, clear, stop
    wr(ssu_pkg::IDX_PINCTL, 8'h0a);
    wr(I_CTL, 8'ha0);
    partner.drive(1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    check({7'h0, start_irq}, 8'h01);
    partner.drive(1'b0, 1'b0);
    partner.drive(1'b1, 1'b0);
    check({7'h0, scl_line}, 8'h00);
    rdc(I_STS, 8'h90);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({7'h0, start_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    @(posedge sys_clk);
    check({7'h0, start_irq}, 8'h01);
    wr(I_STS, 8'h80);
    repeat (2) @(posedge sys_clk);
    check({7'h0, scl_line}, 8'h01);
    partner.drive(1'b1, 1'b1);
    rdc(I_STS, 8'h20);
    wr(I_STS, 8'h20);
    rdc(I_STS, 8'h00);
    // hold variant: an overflow keeps scl low until the flag is cleared
    wr(I_STS, 8'h0f);
    wr(I_CTL, 8'h32);
    repeat (2) @(posedge sys_clk);
    check({7'h0, scl_line}, 8'h00);
    wr(I_STS, 8'h40);
    repeat (2) @(posedge sys_clk);
    check({7'h0, scl_line}, 8'h01);
    report_and_stop();
  end
endmodule
